// [rtcwd_bcd_cnt.sv]
// One BCD time counter with checked load and wrap carry
`timescale 1ns/1ps
module rtcwd_bcd_cnt #(
  parameter logic [7:0] WRAP = 8'h59
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count and load
  input wire logic inc,
  input wire logic ld,
  input wire logic [7:0] ld_val,
  // Result
  output logic [7:0] value,
  output logic carry
);
  typedef struct packed {
    logic [7:0] val;
  } rtcwd_bcd_s;

  rtcwd_bcd_s q, d;
  logic ld_ok;

  // Loads outside the legal BCD range are dropped so the counter never leaves it
  always_comb
  begin
    d = q;
    ld_ok = (ld_val <= WRAP) && (ld_val[3:0] <= 4'h9);
    if (ld && ld_ok)
    begin
      d.val = ld_val;
    end
    else if (inc)
    begin
      if (q.val == WRAP)
        d.val = 8'h00;
      else if (q.val[3:0] == 4'h9)
        d.val = {q.val[7:4] + 4'h1, 4'h0};
      else
        d.val = q.val + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign value = q.val;
  // An accepted write in the same cycle swallows the carry; a refused one lets the count and carry go ahead
  assign carry = inc && !(ld && ld_ok) && (q.val == WRAP);
endmodule

// [rtcwd_host.sv]
// Host processor model driving the byte-wide register bus
`timescale 1ns/1ps
module rtcwd_host (
  // Clock
  input wire logic clk,
  // Byte-wide bus
  output logic bus_sel,
  output logic [14:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata
);
  initial {bus_sel, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
  // One transfer, set up after a falling edge and held across one rising edge
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
    @(negedge clk);
    {bus_sel, bus_wr, bus_rd, bus_addr, bus_wdata} = {1'b1, w, !w, a, d};
    @(negedge clk);
    // Released address and data lines show the inverse so stale values never pass for live ones
    {bus_sel, bus_wr, bus_rd, bus_addr, bus_wdata} = {3'b000, ~a, ~d};
  endtask
endmodule

// [rtcwd_pkg.sv]
// Constants for the timekeeping and watchdog register slice
package rtcwd_pkg;
  // Register byte addresses inside the memory space
  localparam logic [14:0] RTCWD_ADDR_WDOG = 15'h7FF7;
  localparam logic [14:0] RTCWD_ADDR_CTRL = 15'h7FF8;
  localparam logic [14:0] RTCWD_ADDR_SEC = 15'h7FF9;
  localparam logic [14:0] RTCWD_ADDR_MIN = 15'h7FFA;
  localparam logic [14:0] RTCWD_ADDR_HOUR = 15'h7FFB;
  // Field positions
  localparam int RTCWD_WD_STROBE_BIT = 7;
  localparam int RTCWD_WD_LOCK_BIT = 6;
  localparam int RTCWD_OSC_HALT_BIT = 7;
  localparam int RTCWD_CAL_SIGN_BIT = 4;
  // Last legal BCD value of each counter
  localparam logic [7:0] RTCWD_SEC_WRAP = 8'h59;
  localparam logic [7:0] RTCWD_MIN_WRAP = 8'h59;
  localparam logic [7:0] RTCWD_HOUR_WRAP = 8'h23;
  // Values after reset
  localparam logic RTCWD_OSC_HALT_RST = 1'b1;
  localparam logic RTCWD_WD_LOCK_RST = 1'b0;
  localparam logic [5:0] RTCWD_WD_TIMEOUT_RST = 6'h00;
  // Timing: 8 ns clock, 31.25 ms watchdog tick (32 Hz), 32 ticks a second
  localparam int RTCWD_CLK_PERIOD_PS = 8000;
  localparam longint RTCWD_TICK_PERIOD_PS = 64'd31250000000;
  localparam int RTCWD_TICK_CYC = int'(RTCWD_TICK_PERIOD_PS / RTCWD_CLK_PERIOD_PS);
  localparam logic [4:0] RTCWD_TICKS_PER_SEC_M1 = 5'h1F;
  // Clock cycles added or removed per tick for each calibration step
  localparam logic [31:0] RTCWD_CAL_STEP_CYC = 32'h00000001;
endpackage

// [rtcwd_regs.sv]
// Timekeeping counters, oscillator control, calibration and watchdog registers
// Notes on behaviour
// - Hours are BCD 00 to 23 with bits 7 and 6 reading zero and the tens digit 0 to 2.
// - Minutes hold a units digit 0 to 9 in the low nibble and read zero in bit 7.
// - The tens digit of minutes and seconds counts 0 to 5 so both wrap after 59.
// - The calibration sign picks whether the calibration magnitude speeds or slows the time base and is kept without reset.
// - The watchdog expires after its six-bit setting times 31.25 ms ticks.
// - A watchdog setting of zero disables it once a tick has taken it, so it never expires after that tick.
`timescale 1ns/1ps
module rtcwd_regs
  import rtcwd_pkg::*;
#(
  parameter int TICK_CYC = rtcwd_pkg::RTCWD_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte-wide memory side
  input wire logic bus_sel,
  input wire logic [14:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Status
  output logic osc_halt,
  output logic wd_expired
);
  import rtcwd_pkg::*;

  typedef struct packed {
    logic osc_halt;
    logic wd_lock;
    logic [5:0] wd_pend;
    logic [5:0] wd_timeout;
    logic [5:0] wd_cnt;
    logic wd_exp;
    logic [31:0] pre_cnt;
    logic [4:0] sub_tick;
    logic [7:0] rdata;
    logic [31:0] gap;
    logic gap_ok;
  } rtcwd_state_s;

  rtcwd_state_s q, d;
  logic [4:0] cal_q, cal_d;
  logic wr_wdog, wr_ctrl, wr_sec, wr_min, wr_hour;
  logic tick, sec_tick, sec_carry, min_carry;
  logic [31:0] cal_adj, period;
  logic [7:0] sec_v, min_v, hour_v;

  // Address decode for write strobes
  assign wr_wdog = bus_sel && bus_wr && (bus_addr == RTCWD_ADDR_WDOG);
  assign wr_ctrl = bus_sel && bus_wr && (bus_addr == RTCWD_ADDR_CTRL);
  assign wr_sec = bus_sel && bus_wr && (bus_addr == RTCWD_ADDR_SEC);
  assign wr_min = bus_sel && bus_wr && (bus_addr == RTCWD_ADDR_MIN);
  assign wr_hour = bus_sel && bus_wr && (bus_addr == RTCWD_ADDR_HOUR);

  // Tick length: sign one shortens the period, so the clock gains
  assign cal_adj = {28'h0000000, cal_q[3:0]} * RTCWD_CAL_STEP_CYC;
  assign period = cal_q[RTCWD_CAL_SIGN_BIT] ? 32'(TICK_CYC) - cal_adj : 32'(TICK_CYC) + cal_adj;
  // Greater-or-equal so a calibration write that shortens the period never strands the prescaler
  assign tick = !q.osc_halt && (q.pre_cnt >= period - 32'h00000001);
  assign sec_tick = tick && (q.sub_tick == RTCWD_TICKS_PER_SEC_M1);

  // Calibration lives in nonvolatile cells: no reset, only a write changes it
  always_comb
  begin
    cal_d = cal_q;
    if (wr_ctrl)
      cal_d = bus_wdata[4:0];
  end

  always_ff @(posedge clk)
  begin
    cal_q <= cal_d;
  end

  // Time counters chained by carry
  rtcwd_bcd_cnt #(.WRAP(RTCWD_SEC_WRAP)) u_sec (
    .clk(clk),
    .rst(rst),
    .inc(sec_tick),
    .ld(wr_sec),
    .ld_val({1'b0, bus_wdata[6:0]}),
    .value(sec_v),
    .carry(sec_carry)
  );
  rtcwd_bcd_cnt #(.WRAP(RTCWD_MIN_WRAP)) u_min (
    .clk(clk),
    .rst(rst),
    .inc(sec_carry),
    .ld(wr_min),
    .ld_val({1'b0, bus_wdata[6:0]}),
    .value(min_v),
    .carry(min_carry)
  );
  rtcwd_bcd_cnt #(.WRAP(RTCWD_HOUR_WRAP)) u_hour (
    .clk(clk),
    .rst(rst),
    .inc(min_carry),
    .ld(wr_hour),
    .ld_val({2'b00, bus_wdata[5:0]}),
    .value(hour_v),
    .carry()
  );

  // Prescaler, watchdog, control and read data
  always_comb
  begin
    d = q;
    d.wd_exp = 1'b0;
    // Prescaler restarts from zero while halted so the first tick is a full period
    if (q.osc_halt)
    begin
      d.pre_cnt = 32'h00000000;
      d.sub_tick = 5'h00;
    end
    else if (tick)
    begin
      d.pre_cnt = 32'h00000000;
      d.sub_tick = q.sub_tick + 5'h01;
    end
    else
    begin
      d.pre_cnt = q.pre_cnt + 32'h00000001;
    end
    if (wr_ctrl)
      d.osc_halt = bus_wdata[RTCWD_OSC_HALT_BIT];
    // Watchdog counts ticks and fires on the last one of the setting
    if (tick)
    begin
      d.wd_timeout = q.wd_pend;
      if (q.wd_timeout == 6'h00)
        d.wd_cnt = 6'h00;
      else if (q.wd_cnt + 6'h01 == q.wd_timeout)
      begin
        d.wd_cnt = 6'h00;
        d.wd_exp = 1'b1;
      end
      else
        d.wd_cnt = q.wd_cnt + 6'h01;
    end
    if (wr_wdog)
    begin
      // Lock is judged from its value before this write
      if (!q.wd_lock)
        d.wd_pend = bus_wdata[5:0];
      d.wd_lock = bus_wdata[RTCWD_WD_LOCK_BIT];
      if (bus_wdata[RTCWD_WD_STROBE_BIT])
      begin
        d.wd_cnt = 6'h00;
        d.wd_exp = 1'b0;
      end
    end
    // Measure tick spacing for checking; invalid after halt or calibration change
    d.gap = tick ? 32'h00000000 : q.gap + 32'h00000001;
    if (tick)
      d.gap_ok = 1'b1;
    if (q.osc_halt || wr_ctrl)
      d.gap_ok = 1'b0;
    // Registered read, strobe bit always reads zero
    if (bus_sel && bus_rd)
    begin
      unique case (bus_addr)
        RTCWD_ADDR_WDOG: d.rdata = {1'b0, q.wd_lock, q.wd_pend};
        RTCWD_ADDR_CTRL: d.rdata = {q.osc_halt, 2'b00, cal_q};
        RTCWD_ADDR_SEC: d.rdata = sec_v;
        RTCWD_ADDR_MIN: d.rdata = min_v;
        RTCWD_ADDR_HOUR: d.rdata = hour_v;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.osc_halt <= RTCWD_OSC_HALT_RST;
      q.wd_lock <= RTCWD_WD_LOCK_RST;
      q.wd_pend <= RTCWD_WD_TIMEOUT_RST;
      q.wd_timeout <= RTCWD_WD_TIMEOUT_RST;
    end
    else
      q <= d;
  end

  assign bus_rdata = q.rdata;
  assign osc_halt = q.osc_halt;
  assign wd_expired = q.wd_exp;

  // Checks on the counters and the watchdog
  hours_range_a: assert property (@(posedge clk) disable iff (rst)
    hour_v[7:6] == 2'b00 && hour_v[5:4] <= 2'h2 && hour_v[3:0] <= 4'h9 && hour_v <= 8'h23)
    else $error("hours left BCD range");
  min_units_a: assert property (@(posedge clk) disable iff (rst)
    min_v[7] == 1'b0 && min_v[3:0] <= 4'h9)
    else $error("minutes units out of range");
  sec_wrap_a: assert property (@(posedge clk) disable iff (rst)
    (sec_v == 8'h59 && sec_tick && !wr_sec && !wr_min) |=> (sec_v == 8'h00 && min_v != $past(min_v)))
    else $error("seconds did not wrap into minutes");
  // Spacing is checked against the calibration byte itself, not against the period net
  tick_period_a: assert property (@(posedge clk) disable iff (rst)
    (tick && q.gap_ok) |-> (int'(q.gap) + 1 == (cal_q[RTCWD_CAL_SIGN_BIT] ?
      TICK_CYC - int'(cal_q[3:0]) * int'(RTCWD_CAL_STEP_CYC) :
      TICK_CYC + int'(cal_q[3:0]) * int'(RTCWD_CAL_STEP_CYC))))
    else $error("tick spacing does not match calibration");
  wd_fire_a: assert property (@(posedge clk) disable iff (rst)
    (tick && q.wd_timeout != 6'h00 && q.wd_cnt + 6'h01 == q.wd_timeout && !wr_wdog) |=> wd_expired)
    else $error("watchdog missed its timeout");
  wd_off_a: assert property (@(posedge clk) disable iff (rst)
    (q.wd_timeout == 6'h00) |=> !wd_expired)
    else $error("disabled watchdog expired");
  halt_stops_a: assert property (@(posedge clk) disable iff (rst)
    (osc_halt && !wr_sec) |=> $stable(sec_v))
    else $error("seconds moved while halted");

  minute_roll_c: cover property (@(posedge clk) disable iff (rst) min_carry);
  wd_expire_c: cover property (@(posedge clk) disable iff (rst) wd_expired);
  wd_locked_c: cover property (@(posedge clk) disable iff (rst) wr_wdog && q.wd_lock);
endmodule

// [tb_top.sv]
// Self-checking bench for the timekeeping and watchdog register slice
`timescale 1ns/1ps
module tb_top;
  import rtcwd_pkg::*;
  // Short tick keeps a simulated second at 640 cycles
  localparam int TCK = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd_seen = 1'b0;
  logic bus_sel, bus_wr, bus_rd, osc_halt, wd_expired;
  logic [14:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, r8;
  logic [31:0] lfsr_q = 32'h91D2F247;
  logic [7:0] exp_q[$];
  int wd_t[$];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  rtcwd_host host (.clk(clk), .bus_sel(bus_sel), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata));
  rtcwd_regs #(.TICK_CYC(TCK)) DUT (.clk(clk), .rst(rst), .bus_sel(bus_sel), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .osc_halt(osc_halt), .wd_expired(wd_expired));
  // Compare one value and count it
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask
  // The expected byte is queued before the read goes out
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Watchdog period for a calibration byte and a setting of 3
  task automatic wd_gap(input logic [7:0] ctrl, input int per);
    wr(RTCWD_ADDR_CTRL, ctrl);
    rd(RTCWD_ADDR_CTRL, ctrl);
    wr(RTCWD_ADDR_WDOG, 8'h83);
    rd(RTCWD_ADDR_WDOG, 8'h03);
    wd_t.delete();
    repeat (300) @(negedge clk);
    chk("wd_pulses", 8'(wd_t.size() >= 3), 8'h01);
    // The first pulse may straddle the new setting, so time the second gap
    if (wd_t.size() >= 3)
      chk("wd_gap", 8'(wd_t[2] - wd_t[1]), 8'(3 * per));
  endtask
  // Cycle count, expiry times, read tracking and the hang limit
  always @(posedge clk)
  begin
    rd_seen <= bus_sel & bus_rd;
    cyc <= cyc + 1;
    if (wd_expired)
      wd_t.push_back(cyc);
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  // Read data stands from the edge after the read; take it at the falling edge
  always @(negedge clk)
    if (rd_seen)
      chk("bus_rdata", bus_rdata, exp_q.pop_front());
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("osc_halt", {7'h00, osc_halt}, 8'h01);
    rd(RTCWD_ADDR_WDOG, 8'h00);
    rd(RTCWD_ADDR_SEC, 8'h00);
    // Top of each range while halted, then one past it, which is refused
    wr(RTCWD_ADDR_SEC, 8'h59);
    wr(RTCWD_ADDR_MIN, 8'h59);
    wr(RTCWD_ADDR_HOUR, 8'h23);
    wr(RTCWD_ADDR_SEC, 8'h5A);
    wr(RTCWD_ADDR_MIN, 8'h60);
    wr(RTCWD_ADDR_HOUR, 8'h24);
    rd(RTCWD_ADDR_SEC, 8'h59);
    rd(RTCWD_ADDR_MIN, 8'h59);
    rd(RTCWD_ADDR_HOUR, 8'h23);
    // Random legal minutes read back unchanged
    repeat (4)
    begin
      lfsr_q = lfsr(lfsr_q);
      r8 = {1'b0, 3'(lfsr_q[6:4] % 6), 4'(lfsr_q[3:0] % 10)};
      wr(RTCWD_ADDR_MIN, r8);
      rd(RTCWD_ADDR_MIN, r8);
    end
    wr(RTCWD_ADDR_MIN, 8'h59);
    // Start the oscillator; one second later every counter has wrapped
    wr(RTCWD_ADDR_CTRL, 8'h00);
    chk("osc_halt", {7'h00, osc_halt}, 8'h00);
    rd(RTCWD_ADDR_CTRL, 8'h00);
    repeat (32 * TCK + 40) @(negedge clk);
    rd(RTCWD_ADDR_SEC, 8'h00);
    rd(RTCWD_ADDR_MIN, 8'h00);
    rd(RTCWD_ADDR_HOUR, 8'h00);
    // Halted, a full second passes with no count
    wr(RTCWD_ADDR_CTRL, 8'h80);
    rd(RTCWD_ADDR_CTRL, 8'h80);
    repeat (32 * TCK + 40) @(negedge clk);
    rd(RTCWD_ADDR_SEC, 8'h00);
    // Calibration slows then speeds the tick
    wd_gap(8'h04, TCK + 4 * int'(RTCWD_CAL_STEP_CYC));
    wd_gap(8'h14, TCK - 4 * int'(RTCWD_CAL_STEP_CYC));
    // Lock: a setting is taken only when the lock was clear before the write
    wr(RTCWD_ADDR_WDOG, 8'h45);
    rd(RTCWD_ADDR_WDOG, 8'h45);
    wr(RTCWD_ADDR_WDOG, 8'h4A);
    rd(RTCWD_ADDR_WDOG, 8'h45);
    wr(RTCWD_ADDR_WDOG, 8'h0A);
    rd(RTCWD_ADDR_WDOG, 8'h05);
    wr(RTCWD_ADDR_WDOG, 8'h0A);
    rd(RTCWD_ADDR_WDOG, 8'h0A);
    // Strobes 28 cycles apart allow at most two ticks, so a setting of 3 never expires
    wr(RTCWD_ADDR_WDOG, 8'h83);
    wd_t.delete();
    repeat (10)
    begin
      repeat (26) @(negedge clk);
      wr(RTCWD_ADDR_WDOG, 8'h83);
    end
    chk("wd_strobed", 8'(wd_t.size()), 8'h00);
    // Setting zero: no expiry once the setting has been taken
    wr(RTCWD_ADDR_WDOG, 8'h00);
    repeat (2 * TCK) @(negedge clk);
    wd_t.delete();
    repeat (300) @(negedge clk);
    chk("wd_idle", 8'(wd_t.size()), 8'h00);
    repeat (2) @(negedge clk);
    end_of_test();
  end
endmodule
